// ===== hdl/ims_i2c_core.sv
`timescale 1ns/1ps
module ims_i2c_core (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   logic [1:0] line_s;
   logic scl_s, sda_s, scl_d_reg, sda_d_reg;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic [7:0] addr_reg, div_reg, ctrl_reg, sec_reg, wdat, rd_mux;
   logic done_reg, addressed_as_slave_flag_reg, busy_reg, arbitration_lost_flag_reg, srw_reg, rxak_reg;
   logic req, wr_acc, rd_acc, ctl_wr, data_wr, data_rd;
   logic en, wide, mst_up, mst_down, rsta_req, own_hit, byte_go, master, mtx;
   logic arb_hit, start_busy, rsta_bad, stray_stop, arb_lost;
   logic [7:0] tx_shift_reg, rx_shift_reg, rx_data_reg;
   logic [3:0] bit_cnt_reg;
   logic seen_reg, addr_ph_reg, ten2_reg, ten_hit_reg;
   logic slave_on_reg, slave_tx_reg, slave_done_reg, ack_low_reg;
   logic byte_end, bit7_end, gc_hit, head_hit;
   logic m_first, m_back, m_seven, m_second, addr_hit, tx_on, eng_low, hold;
   ims_pkg::ims_mstate_t mstate_reg;
   logic [1:0] mstep_reg;
   logic [11:0] timer_reg, half_len;
   logic t_done, mscl_reg, msda_reg, run_reg, stop_pend_reg, rsta_pend_reg;

   function automatic logic same7(input logic [7:0] a, input logic [7:0] b);
      return a[7:1] == b[7:1];
   endfunction : same7

   ims_line_sync u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin_in({scl_i, sda_i}),
      .pin_out(line_s)
   );

   assign scl_s = line_s[1];
   assign sda_s = line_s[0];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // bus access decode: request taken, ack next cycle, effect at ack edge
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_acc = req & wb_ack_o & wb_we_i & wb_sel_i[0];
   assign rd_acc = req & wb_ack_o & ~wb_we_i;
   assign wdat = wb_dat_i[7:0];
   assign ctl_wr = wr_acc & (wb_adr_i == ims_pkg::OFS_CTRL);
   assign data_wr = wr_acc & (wb_adr_i == ims_pkg::OFS_DATA);
   assign data_rd = rd_acc & (wb_adr_i == ims_pkg::OFS_DATA);

   assign en = ctrl_reg[ims_pkg::CTL_EN];
   assign wide = sec_reg[ims_pkg::SC_WIDE];
   assign master = mstate_reg != ims_pkg::MS_IDLE;
   assign mtx = ctrl_reg[ims_pkg::CTL_TX] | addr_ph_reg;
   assign mst_up = ctl_wr & wdat[ims_pkg::CTL_MST] & ~ctrl_reg[ims_pkg::CTL_MST];
   assign mst_down = ctl_wr & ~wdat[ims_pkg::CTL_MST] & ctrl_reg[ims_pkg::CTL_MST];
   assign rsta_req = ctl_wr & wdat[ims_pkg::CTL_RSTA];
   // own address never sent as call in 7-bit mode
   assign own_hit = data_wr & master & addr_ph_reg & ~wide & same7(wdat, addr_reg);
   assign byte_go = (mstate_reg == ims_pkg::MS_RUN) & ~run_reg & ~stop_pend_reg
      & ~rsta_pend_reg & ((data_wr & mtx & ~own_hit) | (data_rd & ~mtx));

   assign arb_hit = run_reg & scl_rise & ~sda_s & ((bit_cnt_reg != ims_pkg::BIT_ACK) ?
      (mtx & tx_shift_reg[7]) : (~mtx & ~ack_low_reg));
   // start only on free, high bus
   assign start_busy = mst_up & (busy_reg | ~scl_s | ~sda_s);
   assign rsta_bad = rsta_req & ~master;
   assign stray_stop = stop_det & master & (mstate_reg != ims_pkg::MS_STOP);
   assign arb_lost = arb_hit | start_busy | rsta_bad | stray_stop;

   // registers written by software
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         addr_reg <= ims_pkg::RST_ADDR;
         div_reg <= ims_pkg::RST_DIV;
         sec_reg <= ims_pkg::RST_SEC;
      end else if (wr_acc) begin
         if (wb_adr_i == ims_pkg::OFS_ADDR) begin
            addr_reg <= wdat;
         end
         if (wb_adr_i == ims_pkg::OFS_DIV) begin
            div_reg <= wdat;
         end
         if (wb_adr_i == ims_pkg::OFS_SEC) begin
            sec_reg <= wdat & ims_pkg::SEC_MASK;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_reg <= ims_pkg::RST_CTRL;
      end else begin
         if (ctl_wr) begin
            ctrl_reg <= wdat & ims_pkg::CTL_MASK;
         end
         if (arb_lost) begin
            ctrl_reg[ims_pkg::CTL_MST] <= 1'b0;
         end
      end
   end

   always_comb begin
      case (wb_adr_i)
         ims_pkg::OFS_ADDR: rd_mux = addr_reg;
         ims_pkg::OFS_DIV: rd_mux = div_reg;
         ims_pkg::OFS_CTRL: rd_mux = ctrl_reg;
         ims_pkg::OFS_STAT: rd_mux = {done_reg, addressed_as_slave_flag_reg, busy_reg, arbitration_lost_flag_reg, 1'b0,
            srw_reg, 1'b0, rxak_reg};
         ims_pkg::OFS_DATA: rd_mux = rx_data_reg;
         ims_pkg::OFS_SEC: rd_mux = sec_reg;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o) begin
            wb_dat_o <= {24'h00_0000, rd_mux};
         end
      end
   end

   // address matching on the received byte
   assign head_hit = rx_shift_reg[7:1] == {ims_pkg::TEN_PREFIX, sec_reg[2:1]};
   assign gc_hit = addr_ph_reg & sec_reg[ims_pkg::SC_GCEN] & (rx_shift_reg == ims_pkg::GC_ADDR);
   assign m_first = addr_ph_reg & wide & head_hit & ~rx_shift_reg[0];
   assign m_back = addr_ph_reg & wide & head_hit & rx_shift_reg[0] & ten_hit_reg;
   assign m_seven = addr_ph_reg & ~wide & same7(rx_shift_reg, addr_reg);
   // low byte uses top field bit 0
   assign m_second = ten2_reg & ~addr_ph_reg
      & (rx_shift_reg == {sec_reg[ims_pkg::SC_HI_TOP - 2], addr_reg[7:1]});
   assign addr_hit = m_first | m_back | m_seven | m_second | gc_hit;

   assign byte_end = scl_fall & seen_reg & (bit_cnt_reg == ims_pkg::BIT_ACK);
   assign bit7_end = scl_fall & seen_reg & (bit_cnt_reg == ims_pkg::BIT_LAST);

   // byte engine: sample on rise, advance on fall
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bit_cnt_reg <= 4'h0;
         seen_reg <= 1'b0;
         addr_ph_reg <= 1'b0;
         ten2_reg <= 1'b0;
         ten_hit_reg <= 1'b0;
         slave_on_reg <= 1'b0;
         slave_tx_reg <= 1'b0;
         slave_done_reg <= 1'b0;
         ack_low_reg <= 1'b0;
         srw_reg <= 1'b0;
         rxak_reg <= 1'b0;
         tx_shift_reg <= 8'hff;
         rx_shift_reg <= 8'h00;
         rx_data_reg <= 8'h00;
      end else if (start_det || stop_det || !en) begin
         bit_cnt_reg <= 4'h0;
         seen_reg <= 1'b0;
         addr_ph_reg <= start_det & en;
         ten2_reg <= 1'b0;
         slave_on_reg <= 1'b0;
         slave_tx_reg <= 1'b0;
         slave_done_reg <= 1'b0;
         ack_low_reg <= 1'b0;
         if (!start_det) begin
            ten_hit_reg <= 1'b0;
         end
      end else begin
         if (scl_rise && busy_reg) begin
            seen_reg <= 1'b1;
            if (bit_cnt_reg != ims_pkg::BIT_ACK) begin
               rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
            end else if ((run_reg && mtx) || (slave_on_reg && slave_tx_reg)) begin
               rxak_reg <= sda_s;
               slave_done_reg <= slave_on_reg & slave_tx_reg & sda_s;
            end
         end
         if (scl_fall && seen_reg) begin
            seen_reg <= 1'b0;
            if (bit_cnt_reg == ims_pkg::BIT_ACK) begin
               bit_cnt_reg <= 4'h0;
               ack_low_reg <= 1'b0;
               addr_ph_reg <= 1'b0;
            end else begin
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
               tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
            end
         end
         if (bit7_end) begin
            rx_data_reg <= rx_shift_reg;
            if (run_reg) begin
               ack_low_reg <= ~mtx & ~ctrl_reg[ims_pkg::CTL_TXAK];
            end else if (!master) begin
               ten2_reg <= m_first;
               if (addr_ph_reg || ten2_reg) begin
                  ack_low_reg <= addr_hit;
                  slave_on_reg <= addr_hit;
                  if (addr_ph_reg && addr_hit) begin
                     slave_tx_reg <= rx_shift_reg[0] & ~gc_hit;
                     srw_reg <= rx_shift_reg[0] & ~gc_hit;
                  end
                  if (m_second) begin
                     ten_hit_reg <= 1'b1;
                  end
                  if (addr_ph_reg && wide && !m_first && !m_back) begin
                     ten_hit_reg <= 1'b0;
                  end
               end else begin
                  ack_low_reg <= slave_on_reg & ~slave_tx_reg & ~ctrl_reg[ims_pkg::CTL_TXAK];
               end
            end
         end
         if (data_wr && !own_hit) begin
            tx_shift_reg <= wdat;
         end
      end
   end

   // status flags, set wins over clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         done_reg <= 1'b0;
         addressed_as_slave_flag_reg <= 1'b0;
         busy_reg <= 1'b0;
         arbitration_lost_flag_reg <= 1'b0;
      end else begin
         if (byte_end && (run_reg || slave_on_reg)) begin
            done_reg <= 1'b1;
         end else if ((data_rd && !ctrl_reg[ims_pkg::CTL_TX])
               || (data_wr && ctrl_reg[ims_pkg::CTL_TX])) begin
            done_reg <= 1'b0;
         end
         if (bit7_end && !master && addr_ph_reg && addr_hit) begin
            addressed_as_slave_flag_reg <= 1'b1;
         end else if (ctl_wr) begin
            addressed_as_slave_flag_reg <= 1'b0;
         end
         if (start_det) begin
            busy_reg <= 1'b1;
         end else if (stop_det) begin
            busy_reg <= 1'b0;
         end
         if (arb_lost) begin
            arbitration_lost_flag_reg <= 1'b1;
         end else if (wr_acc && wb_adr_i == ims_pkg::OFS_STAT && wdat[ims_pkg::ST_ARBITRATION_LOST_FLAG]) begin
            arbitration_lost_flag_reg <= 1'b0;
         end
      end
   end

   assign half_len = {2'b00, div_reg, 2'b00} + ims_pkg::HALF_MIN;
   assign t_done = timer_reg == 12'h000;

   // master sequencer: start, clocking, stop, repeated start
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mstate_reg <= ims_pkg::MS_IDLE;
         mstep_reg <= 2'h0;
         timer_reg <= 12'h000;
         mscl_reg <= 1'b0;
         msda_reg <= 1'b0;
         run_reg <= 1'b0;
         stop_pend_reg <= 1'b0;
         rsta_pend_reg <= 1'b0;
      end else if (arb_lost || !en) begin
         mstate_reg <= ims_pkg::MS_IDLE;
         mstep_reg <= 2'h0;
         mscl_reg <= 1'b0;
         msda_reg <= 1'b0;
         run_reg <= 1'b0;
         stop_pend_reg <= 1'b0;
         rsta_pend_reg <= 1'b0;
      end else begin
         if (!t_done) begin
            timer_reg <= timer_reg - 12'h001;
         end
         case (mstate_reg)
            ims_pkg::MS_IDLE: begin
               // start: sda falls while scl high
               if (mst_up) begin
                  mstate_reg <= ims_pkg::MS_START;
                  msda_reg <= 1'b1;
                  timer_reg <= half_len;
               end
            end
            ims_pkg::MS_START: begin
               if (t_done) begin
                  mscl_reg <= 1'b1;
                  mstate_reg <= ims_pkg::MS_RUN;
                  mstep_reg <= 2'h0;
                  timer_reg <= half_len;
               end
            end
            ims_pkg::MS_RUN: begin
               // stop or repeated start taken between bytes
               if (mst_down) begin
                  stop_pend_reg <= 1'b1;
               end
               if (rsta_req) begin
                  rsta_pend_reg <= 1'b1;
               end
               if (byte_end) begin
                  run_reg <= 1'b0;
               end
               if (byte_go) begin
                  run_reg <= 1'b1;
                  msda_reg <= 1'b0;
                  timer_reg <= half_len;
               end
               case (mstep_reg)
                  2'h0: begin
                     if (run_reg && t_done) begin
                        mscl_reg <= 1'b0;
                        mstep_reg <= 2'h1;
                     end else if (!run_reg && stop_pend_reg) begin
                        mstate_reg <= ims_pkg::MS_STOP;
                        msda_reg <= 1'b1;
                        timer_reg <= half_len;
                     end else if (!run_reg && rsta_pend_reg) begin
                        mstate_reg <= ims_pkg::MS_RSTA;
                        msda_reg <= 1'b0;
                        timer_reg <= half_len;
                     end
                  end
                  2'h1: begin
                     if (scl_s) begin
                        timer_reg <= half_len;
                        mstep_reg <= 2'h2;
                     end
                  end
                  // first to finish high pulls low
                  2'h2: begin
                     if (!scl_s || t_done) begin
                        mscl_reg <= 1'b1;
                        mstep_reg <= 2'h0;
                        timer_reg <= half_len;
                     end
                  end
                  default: mstep_reg <= 2'h0;
               endcase
            end
            ims_pkg::MS_STOP: begin
               case (mstep_reg)
                  2'h0: begin
                     if (t_done) begin
                        mscl_reg <= 1'b0;
                        mstep_reg <= 2'h1;
                     end
                  end
                  2'h1: begin
                     if (scl_s) begin
                        timer_reg <= half_len;
                        mstep_reg <= 2'h2;
                     end
                  end
                  default: begin
                     if (t_done) begin
                        msda_reg <= 1'b0;
                        mstate_reg <= ims_pkg::MS_IDLE;
                        mstep_reg <= 2'h0;
                        stop_pend_reg <= 1'b0;
                     end
                  end
               endcase
            end
            ims_pkg::MS_RSTA: begin
               case (mstep_reg)
                  2'h0: begin
                     if (t_done) begin
                        mscl_reg <= 1'b0;
                        mstep_reg <= 2'h1;
                     end
                  end
                  2'h1: begin
                     if (scl_s) begin
                        timer_reg <= half_len;
                        mstep_reg <= 2'h2;
                     end
                  end
                  2'h2: begin
                     if (t_done) begin
                        msda_reg <= 1'b1;
                        timer_reg <= half_len;
                        mstep_reg <= 2'h3;
                     end
                  end
                  default: begin
                     if (t_done) begin
                        mscl_reg <= 1'b1;
                        mstate_reg <= ims_pkg::MS_RUN;
                        mstep_reg <= 2'h0;
                        rsta_pend_reg <= 1'b0;
                        timer_reg <= half_len;
                     end
                  end
               endcase
            end
            default: mstate_reg <= ims_pkg::MS_IDLE;
         endcase
      end
   end

   // data and ack drive of the byte engine
   assign tx_on = (run_reg & mtx) | (slave_on_reg & slave_tx_reg & ~slave_done_reg & ~addr_ph_reg);
   assign eng_low = busy_reg & ((bit_cnt_reg == ims_pkg::BIT_ACK) ? ack_low_reg :
      (tx_on & ~tx_shift_reg[7]));
   // slave holds scl low until software serves the byte
   assign hold = slave_on_reg & done_reg & ~master & ~slave_done_reg & ~seen_reg
      & (bit_cnt_reg == 4'h0);

   // pins only pulled low or released
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         scl_oe <= en & (mscl_reg | hold);
         sda_oe <= en & (msda_reg | eng_low);
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end
   end
endmodule : ims_i2c_core

// ===== hdl/ims_line_sync.sv
`timescale 1ns/1ps
module ims_line_sync (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] pin_in,
   output logic [1:0] pin_out
);
   logic [1:0] s1_reg;
   logic [1:0] s2_reg;
   logic [1:0] s3_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s1_reg <= 2'h3;
         s2_reg <= 2'h3;
         s3_reg <= 2'h3;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a line moves once the last two stages agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pin_out <= 2'h3;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               pin_out[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule : ims_line_sync

// ===== hdl/ims_pkg.sv
package ims_pkg;
   // register byte offsets on the bus
   localparam logic [4:0] OFS_ADDR = 5'h00;
   localparam logic [4:0] OFS_DIV = 5'h04;
   localparam logic [4:0] OFS_CTRL = 5'h08;
   localparam logic [4:0] OFS_STAT = 5'h0c;
   localparam logic [4:0] OFS_DATA = 5'h10;
   localparam logic [4:0] OFS_SEC = 5'h14;
   // control register fields
   localparam int CTL_EN = 7;
   localparam int CTL_MST = 5;
   localparam int CTL_TX = 4;
   localparam int CTL_TXAK = 3;
   localparam int CTL_RSTA = 2;
   localparam logic [7:0] CTL_MASK = 8'hb8;
   // status register fields
   localparam int ST_DONE = 7;
   localparam int ST_ARBITRATION_LOST_FLAG = 4;
   // secondary control fields
   localparam int SC_GCEN = 7;
   localparam int SC_WIDE = 6;
   localparam int SC_HI_TOP = 2;
   localparam logic [7:0] SEC_MASK = 8'hc7;
   // reset values
   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic [7:0] RST_DIV = 8'h1f;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_SEC = 8'h00;
   // bus encodings
   localparam logic [4:0] TEN_PREFIX = 5'h1e;
   localparam logic [7:0] GC_ADDR = 8'h00;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // half scl period is div*4 + HALF_MIN system clocks
   localparam logic [11:0] HALF_MIN = 12'h004;

   typedef enum logic [2:0] {
      MS_IDLE = 3'b000,
      MS_START = 3'b001,
      MS_RUN = 3'b010,
      MS_STOP = 3'b011,
      MS_RSTA = 3'b100
   } ims_mstate_t;
endpackage : ims_pkg

// ===== testbench/ims_bus_model.sv
`timescale 1ns/1ps
module ims_bus_model (
   input wire logic scl,
   input wire logic sda,
   output logic scl_dn,
   output logic sda_dn
);
   initial {scl_dn, sda_dn} = 2'h0;
   task automatic hi;
      scl_dn = 1'h0;
      repeat (5000) if (scl !== 1'h1) #4;
      #80;
   endtask : hi
   task automatic lo;
      scl_dn = 1'h1;
      #40;
   endtask : lo
   task automatic start;
      sda_dn = 1'h1;
      #80;
      lo();
   endtask : start
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 8; i >= 0; i--) begin
         sda_dn = i > 0 ? ~b[i - 1] : 1'h0;
         #40;
         hi();
         ack = sda;
         lo();
      end
   endtask : send
   // slave side: sample on rise, ack after eighth fall
   task automatic take(input logic ak, output logic [7:0] b);
      b = 8'h00;
      for (int i = 0; i < 9; i++) begin
         @(posedge scl);
         if (i < 8) b = {b[6:0], sda};
         @(negedge scl);
         #20;
         sda_dn = i == 7 ? ak : 1'h0;
      end
   endtask : take
   task automatic stop;
      sda_dn = 1'h1;
      #40;
      hi();
      sda_dn = 1'h0;
      #80;
   endtask : stop
endmodule : ims_bus_model

// ===== testbench/ims_i2c_core_checker.sv
`timescale 1ns/1ps
module ims_i2c_core_checker (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   chk_ack_req: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
   chk_rd_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper bits");
   chk_rd_unmapped: assert property (wb_ack_o && !wb_we_i && wb_adr_i > ims_pkg::OFS_SEC
      |-> wb_dat_o == 32'h0) else $error("unmapped read");
   chk_sda_drain: assert property (sda_oe |-> !sda_o) else $error("sda high");
   chk_scl_drain: assert property (scl_oe |-> !scl_o) else $error("scl high");
   chk_reset_idle: assert property ($rose(reset_n) |-> !sda_oe && !scl_oe && !wb_ack_o)
      else $error("busy after reset");
endmodule : ims_i2c_core_checker

// ===== testbench/ims_i2c_core_test.sv
`timescale 1ns/1ps
module ims_i2c_core_test;
   logic clk = 1'h0, reset_n = 1'h0, req = 1'h0, we = 1'h0;
   logic [4:0] adr = 5'h00;
   logic [31:0] dat = 32'h0, rdat;
   logic ack, scl_o, scl_oe, sda_o, sda_oe, scl_dn, sda_dn;
   logic [6:0] own;
   int err_total = 0, num_checks = 0, seed = 32'h5163fbbb;
   wire scl = (scl_oe ? scl_o : 1'h1) & ~scl_dn;
   wire sda = (sda_oe ? sda_o : 1'h1) & ~sda_dn;
   always #2 clk = ~clk;
   ims_i2c_core ims_i2c_core_inst (.clk(clk), .reset_n(reset_n), .wb_cyc_i(req),
      .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
   ims_bus_model ims_bus_model_inst (.scl(scl), .sda(sda), .scl_dn(scl_dn), .sda_dn(sda_dn));
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge clk);
      req <= 1'h1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      while (ack !== 1'h1) @(posedge clk);
      q = rdat[7:0];
      req <= 1'h0;
   endtask : bus
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   task automatic frame(input logic [7:0] s, input logic [7:0] b0, input logic [7:0] b1);
      logic [1:0] e;
      logic [7:0] q;
      logic a, h;
      // expected acks, first byte high bit
      h = b0 == {ims_pkg::TEN_PREFIX, s[2:1], 1'h0};
      e = s[6] ? {h, h && b1 == {s[0], own}} : {b0[7:1] == own || b0 == 8'h00 && s[7], 1'h0};
      bus(1'h1, ims_pkg::OFS_SEC, s, q);
      bus(1'h1, ims_pkg::OFS_CTRL, 8'h80, q);
      ims_bus_model_inst.start();
      for (int i = 1; i >= 1 - int'(s[6]); i--) begin
         ims_bus_model_inst.send(i ? b0 : b1, a);
         chk("ack", 8'(!e[i]), 8'(a));
         bus(1'h0, ims_pkg::OFS_STAT, 8'h00, q);
         chk("done", 8'(e[i]), 8'(q[7]));
         if (!s[6]) chk("addressed", 8'(e[i]), 8'(q[6]));
         bus(1'h0, ims_pkg::OFS_DATA, 8'h00, q);
      end
      ims_bus_model_inst.stop();
      $display("test frame %h %h done", s, b0);
   endtask : frame
   initial begin
      logic [7:0] q;
      logic [7:0] t;
      logic [7:0] r;
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      bus(1'h0, ims_pkg::OFS_SEC, 8'h00, q);
      chk("sec_reset", ims_pkg::RST_SEC, q);
      bus(1'h1, ims_pkg::OFS_SEC, 8'hff, q);
      bus(1'h0, ims_pkg::OFS_SEC, 8'h00, q);
      chk("sec_rw", ims_pkg::SEC_MASK, q);
      bus(1'h0, 5'h18, 8'h00, q);
      chk("unmapped", 8'h00, q);
      $display("test registers done");
      own = {2'h1, 5'($random(seed))};
      t = {5'h08, 3'($random(seed))};
      bus(1'h1, ims_pkg::OFS_ADDR, {own, 1'h0}, q);
      frame(8'h00, {own, 1'h0}, 8'h00);
      frame(8'h07, {own, 1'h0}, 8'h00);
      frame(8'h00, {own ^ 7'h01, 1'h0}, 8'h00);
      frame(8'h00, 8'h00, 8'h00);
      frame(8'h80, 8'h00, 8'h00);
      frame(t, {own, 1'h0}, 8'h00);
      frame(t, {ims_pkg::TEN_PREFIX, t[2:1], 1'h0}, {t[0], own});
      frame(t, {ims_pkg::TEN_PREFIX, t[2:1], 1'h0}, {t[0], ~own});
      // master write: start, one address byte, stop
      bus(1'h1, ims_pkg::OFS_CTRL, 8'hb0, q);
      wait (scl === 1'h0);
      fork
         ims_bus_model_inst.take(1'h1, r);
         bus(1'h1, ims_pkg::OFS_DATA, {~own, 1'h0}, q);
      join
      do bus(1'h0, ims_pkg::OFS_STAT, 8'h00, q); while (q[7] !== 1'h1);
      chk("mst_byte", {~own, 1'h0}, r);
      chk("rxak", 8'h00, 8'(q[0]));
      chk("busy", 8'h01, 8'(q[5]));
      chk("arbitration_lost_flag", 8'h00, 8'(q[4]));
      bus(1'h1, ims_pkg::OFS_CTRL, 8'h80, q);
      wait (scl === 1'h1 && sda === 1'h1);
      repeat (8) @(posedge clk);
      bus(1'h0, ims_pkg::OFS_STAT, 8'h00, q);
      chk("busy_end", 8'h00, 8'(q[5]));
      $display("test master write done");
      finish_test();
   end
   initial begin
      #200000;
      err_total++;
      finish_test();
   end
endmodule : ims_i2c_core_test
bind ims_i2c_core ims_i2c_core_checker ims_i2c_core_checker_inst (.clk(clk), .reset_n(reset_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
   .sda_oe(sda_oe));
